// >>> tb/drive_pulse_model.sv
/* Drive module model: one signed travel word per taken operation cycle.
   Assumes take_i marks the tick edge at which the stage samples. */
`timescale 1ns/1ps
`default_nettype none
module drive_pulse_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic take_i,
    input wire logic hold_i,
    input wire logic signed [31:0] next_i,
    output logic signed [31:0] travel_o
);
    // A halted drive reports no travel rather than repeating the last one
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            travel_o <= 32'sh0;
        end else if (take_i) begin
            travel_o <= hold_i ? 32'sh0 : next_i;
        end
    end
endmodule : drive_pulse_model
`default_nettype wire

// >>> tb/gear_clutch_props.sv
/* Port assertions of the transmission stage, bound into its top module.
   Assumes the defines header and the package are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "gear_clutch_defines.svh"
module gear_clutch_props #(
    parameter int OP_CYCLE_CLKS = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic virtual_mode_i,
    input var gear_clutch_pkg::pulse_t out_o,
    input wire logic op_tick_o
);
    import gear_clutch_pkg::*;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic seen;
    logic next_seen;
    logic tv;
    assign tv = op_tick_o & virtual_mode_i;
    // The first tick after reset has no reference, so it only arms the check
    always_comb begin
        next_cnt = op_tick_o ? 32'h0 : cnt + 32'h1;
        next_seen = seen | op_tick_o;
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 32'h0;
            seen <= 1'b0;
        end else begin
            cnt <= next_cnt;
            seen <= next_seen;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_take; tv; endsequence
    sequence s_out; ##2 out_o.valid; endsequence
    property p_out_lat; s_take |-> s_out; endproperty
    property p_out_cause; out_o.valid |-> $past(tv, 2); endproperty
    property p_out_pulse; out_o.valid |=> !out_o.valid; endproperty
    property p_out_hold; !out_o.valid |-> $stable(out_o.travel); endproperty
    property p_tick_per; (op_tick_o && seen) |-> cnt == OP_CYCLE_CLKS - 1; endproperty
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
    property p_mode_rd; (rd_i && addr_i == `OFS_MODE) |=> rdata_o <= `MODE_LAST; endproperty
    property p_teeth_rd;
        (rd_i && addr_i == `OFS_IN_TEETH) |=> rdata_o[31:16] == 16'h0 && rdata_o[15:0] != 16'h0;
    endproperty
    a_out_lat: assert property (p_out_lat) else $error("no output after tick");
    a_out_cause: assert property (p_out_cause) else $error("output without tick");
    a_out_pulse: assert property (p_out_pulse) else $error("output valid too long");
    a_out_hold: assert property (p_out_hold) else $error("travel moved idle");
    a_tick_per: assert property (p_tick_per) else $error("tick period wrong");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_mode_rd: assert property (p_mode_rd) else $error("mode out of range");
    a_teeth_rd: assert property (p_teeth_rd) else $error("tooth count range");
endmodule : gear_clutch_props
bind gear_clutch_top gear_clutch_props #(.OP_CYCLE_CLKS(OP_CYCLE_CLKS)) i_gear_clutch_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .virtual_mode_i(virtual_mode_i), .out_o(out_o), .op_tick_o(op_tick_o));
`default_nettype wire

// >>> tb/tb_top.sv
/* Self-checking bench of the transmission stage.
   Assumes a short operation cycle of 8 clocks. */
`timescale 1ns/1ps
`default_nettype none
`include "gear_clutch_defines.svh"
module tb_top;
    import gear_clutch_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic virtual_mode_i = 1'b0;
    logic source_cv_change_i = 1'b0;
    logic hold = 1'b0;
    logic signed [31:0] nxt = 32'sh0;
    logic signed [31:0] drive_travel_i;
    logic [31:0] rdata_o;
    logic [31:0] v;
    pulse_t out_o;
    logic op_tick_o;
    logic irq_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int chk = 0;
    bit rv = 0;
    longint ti = 1, to = 1, nti = 1, nto = 1, rem = 0, acc, e;
    longint q[$];
    always #10 clk_i = ~clk_i;
    gear_clutch_top #(.OP_CYCLE_CLKS(8)) i_gear_clutch_top (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .virtual_mode_i(virtual_mode_i), .source_cv_change_i(source_cv_change_i),
        .drive_travel_i(drive_travel_i), .out_o(out_o), .op_tick_o(op_tick_o), .irq_o(irq_o));
    drive_pulse_model i_drive_pulse_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .take_i(op_tick_o & virtual_mode_i), .hold_i(hold), .next_i(nxt),
        .travel_o(drive_travel_i));
    ////////////////////////////////////////////////////////////////////////
    task automatic ck(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : ck
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        v = rdata_o;
    endtask : rd
    task automatic wv(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(negedge clk_i);
                k++;
            end while (out_o.valid !== 1'b1 && k < 40);
            ck("valid", 32'h1, {31'h0, out_o.valid});
            @(posedge clk_i);
        end
    endtask : wv
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    // Gear model with carried remainder; ratio only moves at a value change
    always @(negedge clk_i) begin
        if (source_cv_change_i) begin
            ti = nti;
            to = nto;
            rem = 0;
        end
        if (op_tick_o && virtual_mode_i) begin
            acc = rem + longint'(drive_travel_i) * ti;
            rem = acc % to;
            q.push_back(rv ? -(acc / to) : acc / to);
        end
        if (out_o.valid === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            if (chk != 0) ck("travel", chk == 2 ? 32'h0 : e[31:0], out_o.travel);
        end
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        void'($urandom(20871));
        fork
            forever begin
                @(posedge clk_i);
                nxt <= $signed($urandom_range(600, 0));
            end
        join_none
        rd(`OFS_IN_TEETH);
        ck("in teeth", 32'h1, v);
        rd(`OFS_OUT_TEETH);
        ck("out teeth", 32'h1, v);
        rd(8'h3c);
        ck("unmapped", 32'h0, v);
        wr(`OFS_IN_TEETH, 32'h3);
        wr(`OFS_OUT_TEETH, 32'h2);
        wr(`OFS_CTRL, 32'h1);
        rd(`OFS_IN_TEETH);
        ck("in teeth", 32'h1, v);
        ti = 3;
        to = 2;
        @(posedge clk_i);
        virtual_mode_i <= 1'b1;
        rd(`OFS_IN_TEETH);
        ck("in teeth", 32'h3, v);
        hold <= 1'b1;
        wv(3);
        chk = 1;
        hold <= 1'b0;
        wv(6);
        wr(`OFS_CTRL, 32'h3);
        @(posedge clk_i);
        rv = 1;
        wv(4);
        wr(`OFS_CTRL, 32'h1);
        @(posedge clk_i);
        rv = 0;
        wr(`OFS_IN_TEETH, 32'hea60);
        wr(`OFS_OUT_TEETH, 32'hffff);
        rd(`OFS_IN_TEETH);
        ck("in teeth", 32'h3, v);
        wv(3);
        nti = 60000;
        nto = 65535;
        @(posedge clk_i);
        source_cv_change_i <= 1'b1;
        @(posedge clk_i);
        source_cv_change_i <= 1'b0;
        wv(6);
        wr(`OFS_MODE, 32'h5);
        wv(2);
        rd(`OFS_MODE);
        ck("mode", 32'h0, v);
        ck("irq", 32'h0, {31'h0, irq_o});
        wr(`OFS_IRQ_MASK, 32'h4);
        @(negedge clk_i);
        ck("irq", 32'h1, {31'h0, irq_o});
        wr(`OFS_IRQ_STAT, 32'h4);
        @(negedge clk_i);
        ck("irq", 32'h0, {31'h0, irq_o});
        chk = 0;
        wr(`OFS_CTRL, 32'h0);
        wv(2);
        chk = 2;
        wv(4);
        chk = 0;
        wr(`OFS_CTRL, 32'h15);
        wv(3);
        rd(`OFS_STATUS);
        ck("done", 32'h0, {31'h0, v[1]});
        ck("engaged", 32'h1, {31'h0, v[0]});
        wr(`OFS_SLIP_WINDOW, 32'h7fff_ffff);
        wv(5);
        rd(`OFS_STATUS);
        ck("done", 32'h1, {31'h0, v[1]});
        stop_test();
    end
endmodule : tb_top
`default_nettype wire

// >>> verilog/clutch_smoother.sv
/*
 * Clutch: passes or blocks gear travel; a smoothing clutch ramps its
 * engagement factor by time constant, exponential or linear slippage.
 * Assumes one step per operation cycle and engage level held between steps.
 */
`timescale 1ns/1ps
`default_nettype none

module clutch_smoother (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic engage_i,
    input var gear_clutch_pkg::shadow_t cfg_i,
    input var gear_clutch_pkg::pulse_t in_i,
    output gear_clutch_pkg::pulse_t out_o,
    output logic done_o
);
    import gear_clutch_pkg::*;

    logic [8:0] factor;
    logic [8:0] next_factor;
    logic signed [31:0] rest;
    logic signed [31:0] next_rest;
    logic next_done;
    logic prev_engage;
    pulse_t next_out;
    logic [8:0] target;
    logic [8:0] gap;
    logic [8:0] step;
    logic signed [41:0] scaled;
    logic signed [31:0] lost;
    logic [31:0] mag;

    always_comb begin
        target = engage_i ? `FULL_ENGAGE : 9'h000;
        gap = (factor > target) ? factor - target : target - factor;
        step = 9'h000;
        next_factor = factor;
        next_rest = rest;
        next_done = done_o;
        next_out = '{valid: 1'b0, travel: out_o.travel};
        mag = in_i.travel[31] ? 32'(-in_i.travel) : 32'(in_i.travel);
        scaled = '0;
        lost = '0;
        if (in_i.valid) begin
            if (!cfg_i.smoothing) begin
                next_factor = target;
                next_done = 1'b1;
            end else begin
                if (cfg_i.method == METH_LIN_SLIP) begin
                    step = `FULL_ENGAGE >> cfg_i.shift;
                end else begin
                    step = gap >> cfg_i.shift;
                end
                if (step == 9'h000 && gap != 9'h000) begin
                    step = 9'h001;
                end
                if (step > gap) begin
                    step = gap;
                end
                next_factor = (factor < target) ? factor + step : factor - step;
                if (engage_i != prev_engage) begin
                    next_rest = cfg_i.slip;
                    next_done = 1'b0;
                end else if (cfg_i.method == METH_TIME_CONST) begin
                    next_done = (next_factor == target);
                end else begin
                    lost = 32'(({9'h0, mag} * {32'h0, 9'(`FULL_ENGAGE - factor)}) >> 8);
                    next_rest = (rest > lost) ? rest - lost : 32'sh0;
                    next_done = (next_rest < cfg_i.slip_window) && (next_factor == target);
                end
            end
            scaled = (42'(in_i.travel) * $signed({33'h0, next_factor})) >>> 8;
            next_out.valid = 1'b1;
            next_out.travel = (next_factor == 9'h000) ? 32'sh0 : scaled[31:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            factor <= 9'h000;
            rest <= '0;
            done_o <= 1'b1;
            prev_engage <= 1'b0;
            out_o <= '0;
        end else begin
            factor <= next_factor;
            rest <= next_rest;
            done_o <= next_done;
            out_o <= next_out;
            if (in_i.valid) begin
                prev_engage <= engage_i;
            end
        end
    end
endmodule : clutch_smoother

`default_nettype wire

// >>> verilog/gear_clutch_defines.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * gear and clutch transmission stage.
 * Assumes inclusion by bare name from the package, the bench and its property module.
 */
`ifndef GEAR_CLUTCH_DEFINES_SVH
`define GEAR_CLUTCH_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL         8'h00
`define OFS_MODE         8'h04
`define OFS_IN_TEETH     8'h08
`define OFS_OUT_TEETH    8'h0c
`define OFS_SPEED_RATIO  8'h10
`define OFS_SLIP         8'h14
`define OFS_SLIP_WINDOW  8'h18
`define OFS_ON_ADDR      8'h1c
`define OFS_OFF_ADDR     8'h20
`define OFS_SMOOTH_SHIFT 8'h24
`define OFS_STATUS       8'h28
`define OFS_IRQ_STAT     8'h2c
`define OFS_IRQ_MASK     8'h30
`define OFS_AXIS_POS     8'h34

// Control field positions
`define CTRL_CMD_BIT     0
`define CTRL_REV_BIT     1
`define CTRL_SMOOTH_BIT  2
`define CTRL_METH_LSB    3
`define CTRL_METH_MSB    4

// Status and interrupt bit positions
`define ST_ENGAGED_BIT   0
`define ST_DONE_BIT      1
`define ST_VIRTUAL_BIT   2
`define ST_MODE_ERR_BIT  3
`define IRQ_WIDTH        3

// Reset values and the last valid mode code
`define RST_TEETH        16'h0001
`define RST_MODE         3'h0
`define RST_SHIFT        3'h2
`define MODE_LAST        32'h0000_0004

// Clutch engagement in fixed point, full engagement
`define FULL_ENGAGE      9'h100

// Operation cycle timing
`define CLK_PERIOD_NS    20
`define OP_CYCLE_NS      888000

`endif

// >>> verilog/gear_clutch_pkg.sv
/*
 * Types of the gear and clutch transmission stage.
 * Assumes the defines header sits beside it.
 */
`include "gear_clutch_defines.svh"

package gear_clutch_pkg;

    typedef enum logic [2:0] {
        MODE_ON_OFF  = 3'b000,
        MODE_ADDRESS = 3'b001,
        MODE_ADDR2   = 3'b010,
        MODE_ONESHOT = 3'b011,
        MODE_EXT     = 3'b100
    } clutch_mode_t;

    typedef enum logic [1:0] {
        METH_TIME_CONST = 2'b00,
        METH_EXP_SLIP   = 2'b01,
        METH_LIN_SLIP   = 2'b10
    } smooth_method_t;

    // Working copy of the indirectly set items
    typedef struct packed {
        logic engage_cmd;
        logic reverse;
        logic smoothing;
        smooth_method_t method;
        logic [2:0] shift;
        clutch_mode_t mode;
        logic [15:0] in_teeth;
        logic [15:0] out_teeth;
        logic [15:0] speed_ratio;
        logic signed [31:0] slip;
        logic signed [31:0] slip_window;
        logic signed [31:0] on_addr;
        logic signed [31:0] off_addr;
    } shadow_t;

    typedef struct packed {
        logic valid;
        logic signed [31:0] travel;
    } pulse_t;

endpackage : gear_clutch_pkg

// >>> verilog/gear_clutch_top.sv
/*
 * Transmission stage of a virtual mechanical system: register file, mode
 * switch sampling, operation-cycle tick, gear and clutch, interrupt.
 * Assumes drive travel is held valid for the tick that takes it and that
 * the source current-value change arrives as a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module gear_clutch_top #(
    parameter int OP_CYCLE_CLKS = `OP_CYCLE_NS / `CLK_PERIOD_NS
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic virtual_mode_i,
    input wire logic source_cv_change_i,
    input wire logic signed [31:0] drive_travel_i,
    output gear_clutch_pkg::pulse_t out_o,
    output logic op_tick_o,
    output logic irq_o
);
    import gear_clutch_pkg::*;

    if (OP_CYCLE_CLKS < 4) begin : g_bad_cycle
        $error("OP_CYCLE_CLKS must be at least 4");
    end

    function automatic logic [15:0] teeth_of(input logic [31:0] v);
        teeth_of = (v[15:0] == 16'h0000) ? 16'h0001 : v[15:0];
    endfunction : teeth_of

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta;
    logic rst_b;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_b <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation cycle divider

    logic [31:0] div_cnt;
    logic [31:0] next_div_cnt;

    always_comb begin
        next_div_cnt = (div_cnt == 32'(OP_CYCLE_CLKS - 1)) ? 32'h0 : div_cnt + 32'h1;
        op_tick_o = (div_cnt == 32'(OP_CYCLE_CLKS - 1));
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 32'h0;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software setting registers

    shadow_t sw;
    shadow_t next_sw;
    logic [2:0] irq_mask;
    logic [2:0] next_irq_mask;

    always_comb begin
        next_sw = sw;
        next_irq_mask = irq_mask;
        if (wr_i) begin
            unique case (addr_i)
                `OFS_CTRL: begin
                    next_sw.engage_cmd = wdata_i[`CTRL_CMD_BIT];
                    next_sw.reverse = wdata_i[`CTRL_REV_BIT];
                    next_sw.smoothing = wdata_i[`CTRL_SMOOTH_BIT];
                    next_sw.method = smooth_method_t'(wdata_i[`CTRL_METH_MSB:`CTRL_METH_LSB]);
                end
                `OFS_MODE: begin
                    // Out-of-range codes are parked as 7 and caught at sampling
                    next_sw.mode = (wdata_i > `MODE_LAST) ? clutch_mode_t'(3'h7)
                                                          : clutch_mode_t'(wdata_i[2:0]);
                end
                `OFS_IN_TEETH: next_sw.in_teeth = wdata_i[15:0];
                `OFS_OUT_TEETH: next_sw.out_teeth = wdata_i[15:0];
                `OFS_SPEED_RATIO: next_sw.speed_ratio = wdata_i[15:0];
                `OFS_SLIP: next_sw.slip = wdata_i;
                `OFS_SLIP_WINDOW: next_sw.slip_window = wdata_i;
                `OFS_ON_ADDR: next_sw.on_addr = wdata_i;
                `OFS_OFF_ADDR: next_sw.off_addr = wdata_i;
                `OFS_SMOOTH_SHIFT: next_sw.shift = wdata_i[2:0];
                `OFS_IRQ_MASK: next_irq_mask = wdata_i[`IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            sw <= '{in_teeth: `RST_TEETH, out_teeth: `RST_TEETH, speed_ratio: 16'h0001,
                    shift: `RST_SHIFT, mode: MODE_ON_OFF, method: METH_TIME_CONST,
                    default: '0};
            irq_mask <= 3'h0;
        end else begin
            sw <= next_sw;
            irq_mask <= next_irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working copy sampled at the mode switch, then per clock, per operation cycle or at a value change

    shadow_t act;
    shadow_t next_act;
    logic virt_q;
    logic mode_err;
    logic next_mode_err;
    logic ratio_load;
    logic enter_virtual;

    always_comb begin
        enter_virtual = virtual_mode_i && !virt_q;
        ratio_load = enter_virtual || (virtual_mode_i && source_cv_change_i);
        next_act = act;
        next_mode_err = mode_err;
        if (enter_virtual) begin
            next_act = sw;
            next_act.in_teeth = teeth_of({16'h0, sw.in_teeth});
            next_act.out_teeth = teeth_of({16'h0, sw.out_teeth});
            next_mode_err = (sw.mode > MODE_EXT);
            if (sw.mode > MODE_EXT) begin
                next_act.mode = act.mode;
            end
        end else if (virtual_mode_i) begin
            if (ratio_load) begin
                next_act.in_teeth = teeth_of({16'h0, sw.in_teeth});
                next_act.out_teeth = teeth_of({16'h0, sw.out_teeth});
            end
            next_act.reverse = sw.reverse;
            next_act.smoothing = sw.smoothing;
            next_act.method = sw.method;
            next_act.shift = sw.shift;
            if (op_tick_o) begin
                next_act.engage_cmd = sw.engage_cmd;
                next_act.on_addr = sw.on_addr;
                next_act.off_addr = sw.off_addr;
                next_act.slip_window = sw.slip_window;
                next_act.speed_ratio = sw.speed_ratio;
                next_mode_err = (sw.mode > MODE_EXT);
                if (sw.mode <= MODE_EXT) begin
                    next_act.mode = sw.mode;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            act <= '{in_teeth: `RST_TEETH, out_teeth: `RST_TEETH, speed_ratio: 16'h0001,
                     shift: `RST_SHIFT, mode: MODE_ON_OFF, method: METH_TIME_CONST,
                     default: '0};
            virt_q <= 1'b0;
            mode_err <= 1'b0;
        end else begin
            act <= next_act;
            virt_q <= virtual_mode_i;
            mode_err <= next_mode_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Engage decision, axis position and datapath

    logic engaged;
    logic next_engaged;
    logic signed [31:0] axis_pos;
    logic signed [31:0] next_axis_pos;
    pulse_t drive_step;
    pulse_t gear_out;
    logic smooth_done;

    always_comb begin
        next_engaged = engaged;
        next_axis_pos = axis_pos;
        drive_step = '{valid: op_tick_o && virtual_mode_i, travel: drive_travel_i};
        if (!virtual_mode_i) begin
            next_engaged = 1'b0;
        end else if (op_tick_o) begin
            next_axis_pos = axis_pos + drive_travel_i;
            unique case (act.mode)
                MODE_ADDRESS, MODE_ADDR2: begin
                    if (act.engage_cmd && !engaged && next_axis_pos >= act.on_addr) begin
                        next_engaged = 1'b1;
                    end else if (!act.engage_cmd && engaged &&
                                 next_axis_pos >= act.off_addr) begin
                        next_engaged = 1'b0;
                    end
                end
                // One-shot and external modes fall back to plain command control
                default: next_engaged = act.engage_cmd;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            engaged <= 1'b0;
            axis_pos <= '0;
        end else begin
            engaged <= next_engaged;
            axis_pos <= next_axis_pos;
        end
    end

    gear_scaler u_gear (
        .clk_i(clk_i),
        .rst_b_i(rst_b),
        .in_teeth_i(next_act.in_teeth),
        .out_teeth_i(next_act.out_teeth),
        .reverse_i(act.reverse),
        .clear_i(ratio_load),
        .in_i(drive_step),
        .out_o(gear_out)
    );

    clutch_smoother u_clutch (
        .clk_i(clk_i),
        .rst_b_i(rst_b),
        .engage_i(engaged),
        .cfg_i(act),
        .in_i(gear_out),
        .out_o(out_o),
        .done_o(smooth_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: engage change, smoothing complete, mode error

    logic [2:0] irq_stat;
    logic [2:0] next_irq_stat;
    logic engaged_q;
    logic done_q;
    logic [2:0] events;

    always_comb begin
        events = {mode_err && !next_mode_err ? 1'b0 : (next_mode_err && !mode_err),
                  smooth_done && !done_q,
                  engaged != engaged_q};
        next_irq_stat = irq_stat;
        if (wr_i && addr_i == `OFS_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~wdata_i[`IRQ_WIDTH-1:0];
        end
        next_irq_stat = next_irq_stat | events;
        irq_o = |(irq_stat & irq_mask);
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat <= 3'h0;
            engaged_q <= 1'b0;
            done_q <= 1'b1;
        end else begin
            irq_stat <= next_irq_stat;
            engaged_q <= engaged;
            done_q <= smooth_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe

    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0;
        if (rd_i) begin
            unique case (addr_i)
                `OFS_CTRL: next_rdata = {27'h0, sw.method, sw.smoothing, sw.reverse,
                                         sw.engage_cmd};
                `OFS_MODE: next_rdata = {29'h0, act.mode};
                `OFS_IN_TEETH: next_rdata = {16'h0, act.in_teeth};
                `OFS_OUT_TEETH: next_rdata = {16'h0, act.out_teeth};
                `OFS_SPEED_RATIO: next_rdata = {16'h0, act.speed_ratio};
                `OFS_SLIP: next_rdata = sw.slip;
                `OFS_SLIP_WINDOW: next_rdata = sw.slip_window;
                `OFS_ON_ADDR: next_rdata = sw.on_addr;
                `OFS_OFF_ADDR: next_rdata = sw.off_addr;
                `OFS_SMOOTH_SHIFT: next_rdata = {29'h0, sw.shift};
                `OFS_STATUS: next_rdata = {28'h0, mode_err, virtual_mode_i, smooth_done,
                                           engaged};
                `OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
                `OFS_IRQ_MASK: next_rdata = {29'h0, irq_mask};
                `OFS_AXIS_POS: next_rdata = axis_pos;
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            rdata_o <= 32'h0;
        end else begin
            rdata_o <= next_rdata;
        end
    end
endmodule : gear_clutch_top

`default_nettype wire

// >>> verilog/gear_scaler.sv
/*
 * Gear: scales each operation cycle's travel by input over output tooth count,
 * carrying the remainder so that the sum does not drift between ratio loads, and sets direction.
 * Assumes tooth counts are at least one and a step at most once per cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module gear_scaler (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] in_teeth_i,
    input wire logic [15:0] out_teeth_i,
    input wire logic reverse_i,
    input wire logic clear_i,
    input var gear_clutch_pkg::pulse_t in_i,
    output gear_clutch_pkg::pulse_t out_o
);
    import gear_clutch_pkg::*;

    logic signed [49:0] remainder;
    logic signed [49:0] next_remainder;
    pulse_t next_out;
    logic signed [49:0] num;
    logic signed [49:0] quo;
    logic signed [49:0] den;
    logic signed [49:0] rem_in;

    always_comb begin
        den = $signed({34'h0, out_teeth_i});
        // A ratio load restarts the carry but must not swallow the step beside it
        rem_in = clear_i ? '0 : remainder;
        num = $signed({{18{in_i.travel[31]}}, in_i.travel}) * $signed({34'h0, in_teeth_i})
              + rem_in;
        quo = num / den;
        next_remainder = rem_in;
        next_out = '{valid: 1'b0, travel: out_o.travel};
        if (in_i.valid) begin
            next_remainder = num - quo * den;
            next_out.valid = 1'b1;
            next_out.travel = reverse_i ? -quo[31:0] : quo[31:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            remainder <= '0;
            out_o <= '0;
        end else begin
            remainder <= next_remainder;
            out_o <= next_out;
        end
    end
endmodule : gear_scaler

`default_nettype wire
